/* rtl/fb_status_pkg.sv */
`default_nettype none

package fb_status_pkg;

  // APB byte addresses
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_SIG       = 8'h08;
  localparam logic [7:0] ADDR_COUNT     = 8'h0c;
  localparam logic [7:0] ADDR_SIG_STAGE = 8'h10;
  localparam logic [7:0] ADDR_COMMIT    = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STS   = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h1c;
  localparam logic [3:0] PAGE_CFG       = 4'h2;
  localparam logic [3:0] PAGE_PRESENT   = 4'h3;
  localparam logic [3:0] PAGE_EXCH      = 4'h4;
  localparam logic [3:0] PAGE_ALARM     = 4'h5;
  localparam logic [3:0] PAGE_DIAG      = 4'h6;

  // Map geometry
  localparam int          STATIONS  = 127;
  localparam int          MAP_WORDS = 4;
  localparam int          SIG_W     = 16;
  localparam int          COUNT_W   = 8;

  // Reset values
  localparam logic [4:0]  CTRL_RST  = 5'h00;
  localparam logic [15:0] SIG_RST   = 16'h0000;
  localparam logic [3:0]  IRQ_RST   = 4'h0;

  // Interrupt status bit positions
  localparam int IRQ_CONFLICT = 0;
  localparam int IRQ_ALARM    = 1;
  localparam int IRQ_DIAG     = 2;
  localparam int IRQ_LOST     = 3;

  // Back-off time after an address conflict
  localparam int BACKOFF_MS      = 5000;
  localparam int CLK_KHZ         = 50000;
  localparam int BACKOFF_CYC_DEF = BACKOFF_MS * CLK_KHZ;
  localparam int BACKOFF_W       = 28;

  typedef enum logic [1:0] {
    NET_OFFLINE,
    NET_STOPPED,
    NET_CLEAR,
    NET_OPERATE
  } net_state_t;

  typedef struct packed {
    logic       redundancy_role_flag;
    logic       redundancy_enable_flag;
    logic       slave_emulation_flag;
    net_state_t cmd;
  } ctrl_t;

  typedef struct packed {
    logic address_conflict_flag;
    logic redundancy_role_flag;
    logic redundancy_enable_flag;
    logic host_run_flag;
    logic slave_emulation_flag;
    logic net_state_operate_flag;
    logic net_state_clear_flag;
    logic net_state_stopped_flag;
    logic net_state_offline_flag;
  } stat_t;

endpackage : fb_status_pkg

`default_nettype wire

/* rtl/fb_status_map.sv */
`timescale 1ns/100ps
`default_nettype none

module fb_status_map
  import fb_status_pkg::*;
#(
  parameter int BACKOFF_CYC = BACKOFF_CYC_DEF
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  // Fieldbus engine side
  input  wire logic [STATIONS-1:0]   stn_live,
  input  wire logic [STATIONS-1:0]   stn_cyclic,
  input  wire logic [STATIONS-1:0]   stn_alarm_set,
  input  wire logic [STATIONS-1:0]   stn_diag_set,
  input  wire logic                  conflict_det,
  input  wire logic                  host_run,
  // Engine permissions and interrupt
  output var  logic                  bus_talk_en,
  output var  logic                  data_xchg_en,
  output var  logic                  outputs_en,
  output var  logic                  irq
);

  function automatic logic [31:0] map_word(input logic [STATIONS-1:0] m, input logic [1:0] idx);
    logic [127:0] wide;
    wide = {1'b0, m};
    return wide[idx*32 +: 32];
  endfunction : map_word

  function automatic logic [COUNT_W-1:0] popcount(input logic [STATIONS-1:0] m);
    logic [COUNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < STATIONS; i++) begin
      n = n + COUNT_W'(m[i]);
    end
    return n;
  endfunction : popcount

  ctrl_t                  ctrl_r;
  stat_t                  stat_r;
  logic [SIG_W-1:0]       sig_r;
  logic [SIG_W-1:0]       sig_stage_r;
  logic [COUNT_W-1:0]     count_r;
  logic [3:0]             irq_sts_r;
  logic [3:0]             irq_mask_r;
  logic [STATIONS-1:0]    cfg_stage_r;
  logic [STATIONS-1:0]    cfg_r;
  logic [STATIONS-1:0]    present_r;
  logic [STATIONS-1:0]    exch_r;
  logic [STATIONS-1:0]    alarm_r;
  logic [STATIONS-1:0]    diag_r;
  logic [BACKOFF_W-1:0]   backoff_r;
  logic [STATIONS-1:0]    present_nxt;
  logic [STATIONS-1:0]    exch_nxt;
  logic [STATIONS-1:0]    alarm_clr;
  logic [STATIONS-1:0]    diag_clr;
  logic [STATIONS-1:0]    cfg_wmask;
  logic [127:0]           wdata_wide;
  logic [3:0]             irq_ev;
  logic                   wr_acc;
  logic                   talk_nxt;
  logic                   xchg_nxt;
  logic [3:0]             page;
  logic [1:0]             widx;

  // Writes take effect only on the edge that completes the access
  assign wr_acc     = psel && penable && pready && pwrite;
  assign page       = paddr[7:4];
  assign widx       = paddr[3:2];
  assign wdata_wide = {96'h0, pwdata} << (widx * 32);

  always_comb begin
    alarm_clr = '0;
    diag_clr  = '0;
    cfg_wmask = '0;
    if (wr_acc && page == PAGE_ALARM) begin
      alarm_clr = wdata_wide[STATIONS-1:0];
    end
    if (wr_acc && page == PAGE_DIAG) begin
      diag_clr = wdata_wide[STATIONS-1:0];
    end
    if (wr_acc && page == PAGE_CFG) begin
      cfg_wmask = {{(STATIONS-32){1'b0}}, 32'hffff_ffff} << (widx * 32);
    end
  end

  // APB: pready comes in the second access cycle, read data with it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && penable && !pready) begin
        case (page)
          PAGE_CFG:     prdata <= map_word(cfg_stage_r, widx);
          PAGE_PRESENT: prdata <= map_word(present_r, widx);
          PAGE_EXCH:    prdata <= map_word(exch_r, widx);
          PAGE_ALARM:   prdata <= map_word(alarm_r, widx);
          PAGE_DIAG:    prdata <= map_word(diag_r, widx);
          4'h0, 4'h1: begin
            case (paddr)
              ADDR_CTRL:      prdata <= {27'h0, ctrl_r};
              ADDR_STATUS:    prdata <= {23'h0, stat_r};
              ADDR_SIG:       prdata <= {16'h0, sig_r};
              ADDR_COUNT:     prdata <= {24'h0, count_r};
              ADDR_SIG_STAGE: prdata <= {16'h0, sig_stage_r};
              ADDR_COMMIT:    prdata <= 32'h0;
              ADDR_IRQ_STS:   prdata <= {28'h0, irq_sts_r};
              ADDR_IRQ_MASK:  prdata <= {28'h0, irq_mask_r};
              default:        pslverr <= 1'b1;
            endcase
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Control and configuration registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_r      <= ctrl_t'(CTRL_RST);
      sig_stage_r <= SIG_RST;
      irq_mask_r  <= IRQ_RST;
    end else if (wr_acc) begin
      case (paddr)
        ADDR_CTRL:      ctrl_r      <= ctrl_t'(pwdata[4:0]);
        ADDR_SIG_STAGE: sig_stage_r <= pwdata[SIG_W-1:0];
        ADDR_IRQ_MASK:  irq_mask_r  <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Staged station set and signature go live together on commit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_stage_r <= '0;
      cfg_r       <= '0;
      sig_r       <= SIG_RST;
    end else begin
      cfg_stage_r <= (cfg_stage_r & ~cfg_wmask) | (wdata_wide[STATIONS-1:0] & cfg_wmask);
      if (wr_acc && paddr == ADDR_COMMIT && pwdata[0]) begin
        cfg_r <= cfg_stage_r;
        sig_r <= sig_stage_r;
      end
    end
  end

  // Back-off reloads on every detection, so a persisting conflict keeps it silent
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      backoff_r <= '0;
    end else if (conflict_det) begin
      backoff_r <= BACKOFF_W'(BACKOFF_CYC);
    end else if (backoff_r != '0) begin
      backoff_r <= backoff_r - 1'b1;
    end
  end

  assign talk_nxt    = ctrl_r.cmd != NET_OFFLINE && !conflict_det && backoff_r <= 1;
  assign xchg_nxt    = talk_nxt && (ctrl_r.cmd == NET_CLEAR || ctrl_r.cmd == NET_OPERATE);
  assign present_nxt = stn_live & cfg_r;
  assign exch_nxt    = xchg_nxt ? (present_nxt & stn_cyclic) : '0;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus_talk_en  <= 1'b0;
      data_xchg_en <= 1'b0;
      outputs_en   <= 1'b0;
    end else begin
      bus_talk_en  <= talk_nxt;
      data_xchg_en <= xchg_nxt;
      outputs_en   <= talk_nxt && ctrl_r.cmd == NET_OPERATE;
    end
  end

  // Station maps; a raise in the cycle of its unload wins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      present_r <= '0;
      exch_r    <= '0;
      alarm_r   <= '0;
      diag_r    <= '0;
      count_r   <= '0;
    end else begin
      present_r <= present_nxt;
      exch_r    <= exch_nxt;
      alarm_r   <= ((alarm_r & ~alarm_clr) | stn_alarm_set) & present_nxt;
      diag_r    <= ((diag_r & ~diag_clr) | stn_diag_set) & present_nxt;
      count_r   <= popcount(exch_nxt);
    end
  end

  // State is decoded one-hot from the command, so one flag is always set
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stat_r <= '0;
      stat_r.net_state_offline_flag <= 1'b1;
    end else begin
      stat_r.net_state_offline_flag <= ctrl_r.cmd == NET_OFFLINE;
      stat_r.net_state_stopped_flag <= ctrl_r.cmd == NET_STOPPED;
      stat_r.net_state_clear_flag   <= ctrl_r.cmd == NET_CLEAR;
      stat_r.net_state_operate_flag <= ctrl_r.cmd == NET_OPERATE;
      stat_r.slave_emulation_flag   <= ctrl_r.slave_emulation_flag;
      stat_r.host_run_flag          <= host_run;
      stat_r.redundancy_enable_flag <= ctrl_r.redundancy_enable_flag;
      stat_r.redundancy_role_flag   <= ctrl_r.redundancy_role_flag;
      stat_r.address_conflict_flag  <= conflict_det || backoff_r > 1;
    end
  end

  always_comb begin
    irq_ev               = '0;
    irq_ev[IRQ_CONFLICT] = conflict_det;
    irq_ev[IRQ_ALARM]    = |(stn_alarm_set & present_nxt);
    irq_ev[IRQ_DIAG]     = |(stn_diag_set & present_nxt);
    irq_ev[IRQ_LOST]     = |(present_r & ~present_nxt);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_sts_r <= IRQ_RST;
      irq       <= 1'b0;
    end else begin
      if (wr_acc && paddr == ADDR_IRQ_STS) begin
        irq_sts_r <= (irq_sts_r & ~pwdata[3:0]) | irq_ev;
      end else begin
        irq_sts_r <= irq_sts_r | irq_ev;
      end
      irq <= |(irq_sts_r & irq_mask_r);
    end
  end

  a_state_onehot: assert property (@(posedge clk_sys) disable iff (srst)
    $onehot(stat_r[3:0]))
    else $error("state flags not one-hot");

  a_offline_silent: assert property (@(posedge clk_sys) disable iff (srst)
    (ctrl_r.cmd == NET_OFFLINE) |=> !bus_talk_en && stat_r.net_state_offline_flag)
    else $error("talking while offline");

  a_stopped_noxchg: assert property (@(posedge clk_sys) disable iff (srst)
    (ctrl_r.cmd == NET_STOPPED) |=> exch_r == '0 && !data_xchg_en)
    else $error("exchange while stopped");

  a_clear_nooutput: assert property (@(posedge clk_sys) disable iff (srst)
    stat_r.net_state_clear_flag && $stable(ctrl_r) |-> !outputs_en)
    else $error("outputs sent in clear");

  a_operate_flag: assert property (@(posedge clk_sys) disable iff (srst)
    outputs_en |-> stat_r.net_state_operate_flag)
    else $error("outputs without operate flag");

  a_host_run: assert property (@(posedge clk_sys) disable iff (srst)
    ##1 stat_r.host_run_flag == $past(host_run))
    else $error("host run flag mismatch");

  a_backoff_hold: assert property (@(posedge clk_sys) disable iff (srst)
    conflict_det |=> (stat_r.address_conflict_flag && !bus_talk_en) [*8])
    else $error("back-off ended early");

  a_exch_subset: assert property (@(posedge clk_sys) disable iff (srst)
    (exch_r & ~present_r) == '0 && (alarm_r & ~present_r) == '0)
    else $error("map bit on absent station");

  a_count_match: assert property (@(posedge clk_sys) disable iff (srst)
    count_r == popcount(exch_r))
    else $error("count mismatch");

  a_apb_answer: assert property (@(posedge clk_sys) disable iff (srst)
    psel && penable && !pready |=> pready)
    else $error("apb answer late");

  // Mirrors and raises are checked against the sources one edge back
  a_slave_flag: assert property (@(posedge clk_sys) disable iff (srst)
    !srst |=> stat_r.slave_emulation_flag == $past(ctrl_r.slave_emulation_flag))
    else $error("slave emulation flag mismatch");

  a_redund_flags: assert property (@(posedge clk_sys) disable iff (srst)
    !srst |=> stat_r.redundancy_enable_flag == $past(ctrl_r.redundancy_enable_flag)
      && stat_r.redundancy_role_flag == $past(ctrl_r.redundancy_role_flag))
    else $error("redundancy flags mismatch");

  a_present_map: assert property (@(posedge clk_sys) disable iff (srst)
    !srst |=> present_r == $past(stn_live & cfg_r))
    else $error("present map mismatch");

  a_alarm_raise: assert property (@(posedge clk_sys) disable iff (srst)
    !srst |=> ($past(stn_alarm_set & stn_live & cfg_r) & ~alarm_r) == '0)
    else $error("alarm raise lost");

  a_diag_raise: assert property (@(posedge clk_sys) disable iff (srst)
    !srst |=> ($past(stn_diag_set & stn_live & cfg_r) & ~diag_r) == '0)
    else $error("diagnostics raise lost");

  a_sig_commit: assert property (@(posedge clk_sys) disable iff (srst)
    wr_acc && paddr == ADDR_COMMIT && pwdata[0] |=> sig_r == $past(sig_stage_r))
    else $error("signature not committed");

  a_conflict_irq: assert property (@(posedge clk_sys) disable iff (srst)
    conflict_det |=> irq_sts_r[IRQ_CONFLICT])
    else $error("conflict event not latched");

  c_conflict: cover property (@(posedge clk_sys) disable iff (srst) $rose(stat_r.address_conflict_flag));
  c_operate_xchg: cover property (@(posedge clk_sys) disable iff (srst) outputs_en && count_r != '0);
  c_irq: cover property (@(posedge clk_sys) disable iff (srst) $rose(irq));
  c_unmapped: cover property (@(posedge clk_sys) disable iff (srst) pready && pslverr);
  c_station_lost: cover property (@(posedge clk_sys) disable iff (srst) $rose(irq_sts_r[IRQ_LOST]));

endmodule : fb_status_map

`default_nettype wire

/* bench/fb_station_model.sv */
`timescale 1ns/100ps
`default_nettype none

module fb_station_model
  import fb_status_pkg::*;
(
  // Clock
  input  wire logic                clk_sys,
  // Master permissions
  input  wire logic                bus_talk_en,
  input  wire logic                data_xchg_en,
  // Scenario control
  input  wire logic [STATIONS-1:0] want_live,
  // Station answers
  output var  logic [STATIONS-1:0] stn_live,
  output var  logic [STATIONS-1:0] stn_cyclic
);
  always @(posedge clk_sys) begin
    stn_live   <= want_live;
    // A slave only answers cyclic polls that the master may send
    stn_cyclic <= want_live & {STATIONS{bus_talk_en & data_xchg_en}};
  end
endmodule : fb_station_model

`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

module tb_top
  import fb_status_pkg::*;
;
  logic                clk_sys;
  logic                srst;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [7:0]          paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [STATIONS-1:0] stn_live;
  logic [STATIONS-1:0] stn_cyclic;
  logic [STATIONS-1:0] stn_alarm_set;
  logic [STATIONS-1:0] stn_diag_set;
  logic [STATIONS-1:0] want_live;
  logic                conflict_det;
  logic                host_run;
  logic                bus_talk_en;
  logic                data_xchg_en;
  logic                outputs_en;
  logic                irq;
  logic [31:0]         rdat;
  logic                rerr;
  logic [3:0]          pg;
  int                  n_fail;
  int                  total_checks;

  // Short back-off keeps the conflict scenario within a few dozen cycles
  fb_status_map #(.BACKOFF_CYC(20)) dut (
    .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stn_live(stn_live),
    .stn_cyclic(stn_cyclic), .stn_alarm_set(stn_alarm_set),
    .stn_diag_set(stn_diag_set), .conflict_det(conflict_det),
    .host_run(host_run), .bus_talk_en(bus_talk_en),
    .data_xchg_en(data_xchg_en), .outputs_en(outputs_en), .irq(irq)
  );

  fb_station_model stations (
    .clk_sys(clk_sys), .bus_talk_en(bus_talk_en), .data_xchg_en(data_xchg_en),
    .want_live(want_live), .stn_live(stn_live), .stn_cyclic(stn_cyclic)
  );

  always #10 clk_sys = ~clk_sys;

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : acc

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  initial begin
    #200000;
    n_fail++;
    conclude();
  end

  initial begin
    clk_sys = 0; srst = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; stn_alarm_set = '0; stn_diag_set = '0;
    want_live = '0; conflict_det = 0; host_run = 0;
    n_fail = 0; total_checks = 0;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    acc(0, ADDR_STATUS, 0);
    `CHK("status_rst", 32'h1, rdat);
    `CHK("talk_rst", 1'b0, bus_talk_en);
    for (int s = 0; s < 4; s++) begin
      acc(1, ADDR_CTRL, 32'(s));
      acc(0, ADDR_STATUS, 0);
      `CHK("state_flags", 32'h1 << s, rdat);
      `CHK("talk", 1'(s != 0), bus_talk_en);
      `CHK("xchg", 1'(s >= 2), data_xchg_en);
      `CHK("outputs", 1'(s == 3), outputs_en);
    end
    host_run <= 1'b1;
    acc(1, ADDR_CTRL, 32'h1f);
    acc(0, ADDR_STATUS, 0);
    `CHK("slave", 1'b1, rdat[4]);
    `CHK("host_run", 1'b1, rdat[5]);
    `CHK("red_en", 1'b1, rdat[6]);
    `CHK("mode_flags", 32'hf8, rdat);
    host_run <= 1'b0;
    acc(1, ADDR_CTRL, 32'h3);
    acc(0, ADDR_STATUS, 0);
    `CHK("standby", 32'h8, rdat);
    acc(1, ADDR_SIG_STAGE, 32'h5a3c);
    acc(0, ADDR_SIG, 0);
    `CHK("sig_early", 32'h0, rdat);
    acc(1, {PAGE_CFG, 4'h0}, 32'h3);
    acc(1, {PAGE_CFG, 4'hc}, 32'h4000_0000);
    acc(1, ADDR_COMMIT, 32'h1);
    acc(0, ADDR_SIG, 0);
    `CHK("sig", 32'h5a3c, rdat);
    // Station 2 is live but never configured, so it must stay out of every map
    want_live <= (127'd1 << 126) | 127'd7;
    repeat (3) @(posedge clk_sys);
    for (int k = 0; k < 4; k++) begin
      acc(0, {PAGE_PRESENT, 2'(k), 2'b00}, 0);
      `CHK("present", (k == 0) ? 32'h3 : (k == 3) ? 32'h4000_0000 : 32'h0, rdat);
      acc(0, {PAGE_EXCH, 2'(k), 2'b00}, 0);
      `CHK("exchange", (k == 0) ? 32'h3 : (k == 3) ? 32'h4000_0000 : 32'h0, rdat);
    end
    acc(0, ADDR_COUNT, 0);
    `CHK("count", 32'h3, rdat);
    acc(1, ADDR_CTRL, 32'h1);
    repeat (3) @(posedge clk_sys);
    acc(0, {PAGE_EXCH, 4'h0}, 0);
    `CHK("stop_exch", 32'h0, rdat);
    acc(0, {PAGE_PRESENT, 4'h0}, 0);
    `CHK("stop_present", 32'h3, rdat);
    acc(0, ADDR_COUNT, 0);
    `CHK("stop_count", 32'h0, rdat);
    acc(1, ADDR_CTRL, 32'h2);
    repeat (3) @(posedge clk_sys);
    acc(0, ADDR_COUNT, 0);
    `CHK("clear_count", 32'h3, rdat);
    for (int i = 0; i < 2; i++) begin
      pg = (i == 0) ? PAGE_ALARM : PAGE_DIAG;
      @(posedge clk_sys);
      if (i == 0) stn_alarm_set <= 127'h6;
      else stn_diag_set <= 127'h6;
      @(posedge clk_sys);
      stn_alarm_set <= '0;
      stn_diag_set  <= '0;
      acc(0, {pg, 4'h0}, 0);
      `CHK("pending", 32'h2, rdat);
      `CHK("irq_masked", 1'b0, irq);
      acc(1, ADDR_IRQ_MASK, 32'h6);
      acc(0, ADDR_IRQ_STS, 0);
      `CHK("irq_sts", 1'b1, rdat[1+i]);
      `CHK("irq_on", 1'b1, irq);
      acc(1, {pg, 4'h0}, 32'h2);
      acc(0, {pg, 4'h0}, 0);
      `CHK("unloaded", 32'h0, rdat);
      acc(1, ADDR_IRQ_MASK, 32'h0);
      acc(1, ADDR_IRQ_STS, 32'h6);
      repeat (2) @(posedge clk_sys);
      `CHK("irq_off", 1'b0, irq);
    end
    @(posedge clk_sys);
    conflict_det <= 1'b1;
    @(posedge clk_sys);
    conflict_det <= 1'b0;
    acc(0, ADDR_STATUS, 0);
    `CHK("conflict", 9'h104, rdat[8:0]);
    `CHK("silent", 1'b0, bus_talk_en);
    repeat (25) @(posedge clk_sys);
    `CHK("talk_back", 1'b1, bus_talk_en);
    acc(0, ADDR_STATUS, 0);
    `CHK("conflict_gone", 9'h004, rdat[8:0]);
    acc(0, ADDR_IRQ_STS, 0);
    `CHK("conflict_irq", 32'h1, rdat);
    want_live <= 127'd7;
    repeat (3) @(posedge clk_sys);
    acc(0, {PAGE_PRESENT, 4'hc}, 0);
    `CHK("present_gone", 32'h0, rdat);
    acc(0, ADDR_IRQ_STS, 0);
    `CHK("lost_irq", 32'h9, rdat);
    acc(0, 8'h70, 0);
    `CHK("unmapped_err", 1'b1, rerr);
    `CHK("unmapped_data", 32'h0, rdat);
    conclude();
  end
endmodule : tb_top

`default_nettype wire
